/* design/lfsf_regs.vh */
// Overview of operation
// - The bus-clamp flag latches when the bus stays dominant past the timeout, and clears on a read after recovery.
// - The transceiver-mode flag reads 1 while the channel is in transmit/receive mode and 0 otherwise, live.
// - The transceiver-mode flag drops when a command leaves that mode or a transmit-dominant fault forces it out.
// - The flag read command 0x2780 never clears the live transceiver-mode and wake-receiver flags.
// - The wake-receiver flag reads 1 when sleep with wake-up enabled is configured, and 0 when wake-up is off.
// - The wake-source flag sets on a detected wake event and clears on its read alone.
// - The termination ground-short flag latches on the fault and clears on a read after recovery.
// - The overtemperature flag latches while hot and clears on a read after cooling below threshold.
// - The receive-low flag latches on a receive pin short to ground and clears on a read after recovery.
// - The receive-high flag latches on a receive pin short to recessive and clears on a read after recovery.
// - The transmit-dominant flag latches on a transmit pin short and clears on a read after recovery.
// - Every serial frame returns the fixed status byte first, whatever the command.
// - A write command, type bits 01 in frame bits 15-14, returns fixed status then extended status.
// - A read command, type bits 00 or 11, returns only the fixed status byte as status.
`ifndef LFSF_REGS_VH
`define LFSF_REGS_VH

// serial frame
`define LFSF_FRAME_BITS 5'h10
`define LFSF_BYTE_BITS 5'h08
`define LFSF_CTYPE_HI 15
`define LFSF_CTYPE_LO 14
`define LFSF_CTYPE_WRITE 2'h1
`define LFSF_CMD_FLAG_RD 16'h2780
`define LFSF_CMD_FLAG_HI 8'h27
`define LFSF_CMD_WAKE_RD 16'h2580
`define LFSF_CMD_WAKE_HI 8'h25

// flag byte positions
`define LFSF_FLG_CLAMP 0
`define LFSF_FLG_TRX 1
`define LFSF_FLG_WAKE_RX 2
`define LFSF_FLG_TERM 3
`define LFSF_FLG_OVT 4
`define LFSF_FLG_RXL 5
`define LFSF_FLG_RXH 6
`define LFSF_FLG_TXD 7

// status bits merged with this channel's pending flags
`define LFSF_FIX_LIN_G 3
`define LFSF_EXT_LIN1 4

// pin synchroniser lane order and reset levels
`define LFSF_PIN_W 10
`define LFSF_PIN_RST 10'h002

// dominant timeout
`define LFSF_CLK_NS 10
`define LFSF_T_DOM_NS 8000
`define LFSF_T_DOM_CYC ((`LFSF_T_DOM_NS + `LFSF_CLK_NS - 1) / `LFSF_CLK_NS)

`endif

/* design/lfsf_sync.v */
`timescale 1ns/1ps
module lfsf_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // asynchronous lanes in, filtered lanes out
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_ff;
    reg [W-1:0] s2_ff;
    reg [W-1:0] s3_ff;
    wire [W-1:0] agree;

    // a lane moves only once stages two and three agree, so a single metastable sample is ignored
    assign agree = ~(s2_ff ^ s3_ff);

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            dout <= (s3_ff & agree) | (dout & ~agree);
        end
    end
endmodule // lfsf_sync

/* design/lfsf_top.v */
`timescale 1ns/1ps
`include "lfsf_regs.vh"
module lfsf_top (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // serial port pins
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    output wire spi_miso,
    output wire spi_miso_oe_n,
    // fault and wake detectors, asynchronous
    input wire lin_bus_dominant,
    input wire term_ground_short,
    input wire thermal_above,
    input wire rxd_short_low,
    input wire rxd_short_high,
    input wire txd_short_low,
    input wire lin_wake_detect,
    // mode control from the chip state machine, same clock
    input wire lin_trx_request,
    input wire lin_sleep_wake_en,
    // status of the rest of the chip, same clock
    input wire [7:0] fix_status_in,
    input wire [7:0] ext_status_in,
    // channel state
    output wire lin_trx_enable,
    output wire [7:0] lin_flags,
    output wire wake_source_flag
);
    // pin lane order: 0 sck, 1 cs_n, 2 mosi, 3 dominant, 4 term, 5 ovt, 6 rxl, 7 rxh, 8 txd, 9 wake
    wire [`LFSF_PIN_W-1:0] pin_q;
    wire sck_q;
    wire cs_n_q;
    wire mosi_q;
    wire dom_q;
    wire term_q;
    wire ovt_q;
    wire rxl_q;
    wire rxh_q;
    wire txd_q;
    wire wake_q;

    lfsf_sync #(
        .W(`LFSF_PIN_W),
        .RST_VAL(`LFSF_PIN_RST)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .din({lin_wake_detect, txd_short_low, rxd_short_high, rxd_short_low, thermal_above,
              term_ground_short, lin_bus_dominant, spi_mosi, spi_cs_n, spi_sck}),
        .dout(pin_q)
    );

    assign sck_q = pin_q[0];
    assign cs_n_q = pin_q[1];
    assign mosi_q = pin_q[2];
    assign dom_q = pin_q[3];
    assign term_q = pin_q[4];
    assign ovt_q = pin_q[5];
    assign rxl_q = pin_q[6];
    assign rxh_q = pin_q[7];
    assign txd_q = pin_q[8];
    assign wake_q = pin_q[9];

    // latched fault: the condition sets, a read clears only when the condition is gone
    function latch_next;
        input cond;
        input flag;
        input rd;
        begin
            latch_next = cond | (flag & ~rd);
        end
    endfunction

    // serial frame state
    reg sck_prev_ff;
    reg cs_prev_ff;
    reg [4:0] bit_cnt_ff;
    reg [15:0] rx_ff;
    reg [7:0] tx_ff;
    wire sck_rise;
    wire sck_fall;
    wire cs_start;
    wire cs_end;
    wire frame_ok;
    wire flag_rd;
    wire wake_rd;
    reg [7:0] second_byte;

    assign sck_rise = ~cs_n_q & sck_q & ~sck_prev_ff;
    assign sck_fall = ~cs_n_q & ~sck_q & sck_prev_ff;
    assign cs_start = cs_prev_ff & ~cs_n_q;
    assign cs_end = ~cs_prev_ff & cs_n_q;
    // frames of any other length are ignored so a glitched frame never clears a flag
    assign frame_ok = cs_end & (bit_cnt_ff == `LFSF_FRAME_BITS);
    assign flag_rd = frame_ok & (rx_ff == `LFSF_CMD_FLAG_RD);
    assign wake_rd = frame_ok & (rx_ff == `LFSF_CMD_WAKE_RD);

    // channel flags
    reg clamp_ff;
    reg term_ff;
    reg ovt_ff;
    reg rxl_ff;
    reg rxh_ff;
    reg txd_ff;
    reg wake_src_ff;
    reg trx_ff;
    reg wake_rx_ff;
    reg trx_req_prev_ff;
    reg [15:0] dom_cnt_ff;
    wire dom_timeout;
    wire lin_pending;

    assign dom_timeout = (dom_cnt_ff == `LFSF_T_DOM_CYC);

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            dom_cnt_ff <= 16'h0000;
        end else if (!dom_q) begin
            dom_cnt_ff <= 16'h0000;
        end else if (!dom_timeout) begin
            dom_cnt_ff <= dom_cnt_ff + 16'h0001;
        end
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            clamp_ff <= 1'b0;
            term_ff <= 1'b0;
            ovt_ff <= 1'b0;
            rxl_ff <= 1'b0;
            rxh_ff <= 1'b0;
            txd_ff <= 1'b0;
            wake_src_ff <= 1'b0;
        end else begin
            clamp_ff <= latch_next(dom_timeout, clamp_ff, flag_rd);
            term_ff <= latch_next(term_q, term_ff, flag_rd);
            ovt_ff <= latch_next(ovt_q, ovt_ff, flag_rd);
            rxl_ff <= latch_next(rxl_q, rxl_ff, flag_rd);
            rxh_ff <= latch_next(rxh_q, rxh_ff, flag_rd);
            txd_ff <= latch_next(txd_q, txd_ff, flag_rd);
            // wake source clears on its own read, not the flag read; a new event in the clearing cycle still wins
            wake_src_ff <= wake_q | (wake_src_ff & ~wake_rd);
        end
    end

    // live mode flags; the read commands have no path into them
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            trx_ff <= 1'b0;
            wake_rx_ff <= 1'b0;
            trx_req_prev_ff <= 1'b0;
        end else begin
            trx_req_prev_ff <= lin_trx_request;
            // a transmit short forces the mode off; only a fresh request brings it back
            trx_ff <= lin_trx_request & ~txd_q &
                      (trx_ff | ~trx_req_prev_ff);
            wake_rx_ff <= lin_sleep_wake_en;
        end
    end

    assign lin_trx_enable = trx_ff;
    assign lin_pending = clamp_ff | term_ff | ovt_ff | rxl_ff | rxh_ff | txd_ff | wake_src_ff;

    assign lin_flags[`LFSF_FLG_CLAMP] = clamp_ff;
    assign lin_flags[`LFSF_FLG_TRX] = trx_ff;
    assign lin_flags[`LFSF_FLG_WAKE_RX] = wake_rx_ff;
    assign lin_flags[`LFSF_FLG_TERM] = term_ff;
    assign lin_flags[`LFSF_FLG_OVT] = ovt_ff;
    assign lin_flags[`LFSF_FLG_RXL] = rxl_ff;
    assign lin_flags[`LFSF_FLG_RXH] = rxh_ff;
    assign lin_flags[`LFSF_FLG_TXD] = txd_ff;
    assign wake_source_flag = wake_src_ff;

    // second byte chosen from the command byte, bits 15-8 of the frame
    always @* begin
        if (rx_ff[7:6] == `LFSF_CTYPE_WRITE) begin
            second_byte = ext_status_in;
            second_byte[`LFSF_EXT_LIN1] = ext_status_in[`LFSF_EXT_LIN1] | lin_pending;
        end else if (rx_ff[7:0] == `LFSF_CMD_FLAG_HI) begin
            second_byte = lin_flags;
        end else if (rx_ff[7:0] == `LFSF_CMD_WAKE_HI) begin
            second_byte = {7'h00, wake_src_ff};
        end else begin
            second_byte = 8'h00;
        end
    end

    // sck is sampled, so it must stay well below a quarter of clk_sys
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            sck_prev_ff <= 1'b0;
            cs_prev_ff <= 1'b1;
            bit_cnt_ff <= 5'h00;
            rx_ff <= 16'h0000;
            tx_ff <= 8'h00;
        end else begin
            sck_prev_ff <= sck_q;
            cs_prev_ff <= cs_n_q;
            if (cs_start) begin
                bit_cnt_ff <= 5'h00;
                tx_ff <= fix_status_in;
                tx_ff[`LFSF_FIX_LIN_G] <= fix_status_in[`LFSF_FIX_LIN_G] | lin_pending;
            end else if (sck_rise) begin
                rx_ff <= {rx_ff[14:0], mosi_q};
                if (bit_cnt_ff != 5'h1f) begin
                    bit_cnt_ff <= bit_cnt_ff + 5'h01;
                end
            end else if (sck_fall) begin
                if (bit_cnt_ff == `LFSF_BYTE_BITS) begin
                    tx_ff <= second_byte;
                end else begin
                    tx_ff <= {tx_ff[6:0], 1'b0};
                end
            end
        end
    end

    assign spi_miso = tx_ff[7];
    assign spi_miso_oe_n = cs_n_q;
endmodule // lfsf_top

/* sim/lfsf_chk.sv */
`timescale 1ns/1ps
module lfsf_chk (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // serial pins
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    input wire spi_miso,
    input wire spi_miso_oe_n,
    // detectors
    input wire lin_bus_dominant,
    input wire term_ground_short,
    input wire thermal_above,
    input wire rxd_short_low,
    input wire rxd_short_high,
    input wire txd_short_low,
    input wire lin_wake_detect,
    // mode and status
    input wire lin_trx_request,
    input wire lin_sleep_wake_en,
    input wire [7:0] fix_status_in,
    input wire [7:0] ext_status_in,
    input wire lin_trx_enable,
    input wire [7:0] lin_flags,
    input wire wake_source_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    trx_off_a: assert property (!lin_trx_request |=> !lin_trx_enable)
        else $error("trx flag without request");
    // the tx short pin must have been clear long enough for the filtered copy to be clear too
    trx_on_a: assert property (!txd_short_low [*6] ##0 ($rose(lin_trx_request) && !lin_flags[7])
        |=> lin_trx_enable) else $error("trx flag missed request");
    wake_rx_a: assert property (!$past(sys_rst) |-> lin_flags[2] == $past(lin_sleep_wake_en))
        else $error("wake receiver flag wrong");
    txd_drop_a: assert property ($rose(lin_flags[7]) |=> !lin_trx_enable)
        else $error("trx flag kept after tx short");
    // pin held six cycles so the filtered copy surely shows it
    ovt_hold_a: assert property (thermal_above [*6] ##0 lin_flags[4] |=> lin_flags[4])
        else $error("overtemp flag lost while hot");
    term_set_a: assert property (term_ground_short [*7] |-> lin_flags[3])
        else $error("term short flag not set");
    clamp_clr_a: assert property ($fell(lin_flags[0]) |-> $past(spi_miso_oe_n))
        else $error("clamp flag cleared outside read");
    wake_clr_a: assert property ($fell(wake_source_flag) |-> $past(spi_miso_oe_n))
        else $error("wake source cleared outside read");
    cover property ($rose(lin_flags[0]));
    cover property ($fell(wake_source_flag));
    cover property ($fell(lin_flags[4]));
endmodule // lfsf_chk
bind lfsf_top lfsf_chk u_chk (.*);

/* sim/lfsf_spi_mst.sv */
`timescale 1ns/1ps
module lfsf_spi_mst (
    // clock
    input wire clk_sys,
    // serial pins
    output reg spi_sck,
    output reg spi_cs_n,
    output reg spi_mosi,
    input wire spi_miso,
    input wire spi_miso_oe_n
);
    // half period in system clocks, 6 at least
    integer half = 8;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // undriven miso is taken as unknown so it can never match
    task xfer(input [15:0] cmd, output [15:0] rsp);
        integer i;
        begin
            @(posedge clk_sys) spi_cs_n <= 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                spi_mosi <= cmd[i];
                repeat (half) @(posedge clk_sys);
                spi_sck <= 1'b1;
                rsp = {rsp[14:0], spi_miso_oe_n ? 1'bx : spi_miso};
                repeat (half) @(posedge clk_sys);
                spi_sck <= 1'b0;
            end
            repeat (half) @(posedge clk_sys);
            spi_cs_n <= 1'b1;
            spi_mosi <= ~cmd[0];
            repeat (10) @(posedge clk_sys);
        end
    endtask
endmodule // lfsf_spi_mst

/* sim/lfsf_tb.sv */
`timescale 1ns/1ps
module testbench;
    reg clk_sys, sys_rst, dom, term, ovt, rxl, rxh, txd, wake, trx_req, swe;
    reg [7:0] fix, ext;
    reg [15:0] rsp;
    wire sck, cs_n, mosi, miso, oe_n, trx_en, wsrc;
    wire [7:0] flags;
    integer failures = 0;
    integer comparisons = 0;
    integer cyc = 0;
    lfsf_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(oe_n), .lin_bus_dominant(dom),
        .term_ground_short(term), .thermal_above(ovt), .rxd_short_low(rxl),
        .rxd_short_high(rxh), .txd_short_low(txd), .lin_wake_detect(wake),
        .lin_trx_request(trx_req), .lin_sleep_wake_en(swe), .fix_status_in(fix),
        .ext_status_in(ext), .lin_trx_enable(trx_en), .lin_flags(flags),
        .wake_source_flag(wsrc));
    lfsf_spi_mst mst (.clk_sys(clk_sys), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(oe_n));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            conclude;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task xf(input [15:0] cmd, input [15:0] exp);
        begin
            mst.xfer(cmd, rsp);
            chk(rsp, exp);
        end
    endtask
    task cf(input [7:0] exp);
        chk({8'h00, flags}, {8'h00, exp});
    endtask
    task wt(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    task conclude;
        begin
            $display("comparisons %0d failures %0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        sys_rst = 1'b1;
        {dom, term, ovt, rxl, rxh, txd, wake, trx_req, swe} = 9'h000;
        fix = 8'ha5;
        ext = 8'h4b;
        wt(5);
        sys_rst <= 1'b0;
        wt(6);
        xf(16'h4000, 16'ha54b);
        xf(16'h0000, 16'ha500);
        xf(16'hc000, 16'ha500);
        mst.half = 20;
        xf(16'h7f00, 16'ha54b);
        mst.half = 8;
        trx_req <= 1'b1;
        swe <= 1'b1;
        wt(3);
        cf(8'h06);
        chk({15'h0000, trx_en}, 16'h0001);
        xf(16'h2780, 16'ha506);
        cf(8'h06);
        // every fault except bus dominant at once, tx short also drops the mode flag
        {term, ovt, rxl, rxh, txd} <= 5'h1f;
        wt(8);
        cf(8'hfc);
        chk({15'h0000, trx_en}, 16'h0000);
        xf(16'h4000, 16'had5b);
        xf(16'h2780, 16'hadfc);
        cf(8'hfc);
        {term, ovt, rxl, rxh, txd} <= 5'h00;
        wt(8);
        cf(8'hfc);
        xf(16'h2780, 16'hadfc);
        cf(8'h04);
        trx_req <= 1'b0;
        wt(3);
        trx_req <= 1'b1;
        wt(3);
        cf(8'h06);
        dom <= 1'b1;
        wt(790);
        cf(8'h06);
        wt(30);
        cf(8'h07);
        dom <= 1'b0;
        wt(8);
        xf(16'h2780, 16'had07);
        cf(8'h06);
        wake <= 1'b1;
        wt(6);
        wake <= 1'b0;
        wt(8);
        chk({15'h0000, wsrc}, 16'h0001);
        xf(16'h2780, 16'had06);
        chk({15'h0000, wsrc}, 16'h0001);
        mst.xfer(16'h2580, rsp);
        chk(rsp, 16'had01);
        chk({15'h0000, wsrc}, 16'h0000);
        swe <= 1'b0;
        wt(3);
        cf(8'h02);
        sys_rst <= 1'b1;
        wt(2);
        cf(8'h00);
        chk({15'h0000, oe_n}, 16'h0001);
        sys_rst <= 1'b0;
        wt(3);
        cf(8'h02);
        conclude;
    end
endmodule // testbench
